// file: hw/opamp_cfg_pkg.sv
/*
  Constants for the amplifier configuration register bank: register
  indices, field positions, reset values, field encodings and the
  gain code table.
  Assumes a byte-wide register map reached over a 32-bit Avalon-MM
  slave, one register to each aligned word.
*/
package opamp_cfg_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  // printed offsets are not multiples of four: they are indices,
  // the byte address on the bus is four times the index
  localparam logic [11:0] IDX_A_CTL0 = 12'hf94;
  localparam logic [11:0] IDX_A_CTL1 = 12'hf95;
  localparam logic [11:0] IDX_B_CTL0 = 12'hf96;
  localparam logic [11:0] IDX_B_CTL1 = 12'hf97;
  localparam int ADDR_W = 14;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_A_CTL0 = 8'h00;
  localparam logic [7:0] RST_A_CTL1 = 8'h00;
  localparam logic [7:0] RST_B_CTL0 = 8'h00;
  localparam logic [7:0] RST_B_CTL1 = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int OUTCON_BIT = 7;
  localparam int INP_LO = 0;
  localparam int GAIN_LO = 4;
  localparam int POWER_BIT = 3;
  localparam int INN_LO = 0;
  // writable bits: control 0 of amp A keeps 7 and 1:0 plus stored
  // reserved 6:2 (read/write); control 1 keeps all but bit 2
  localparam logic [7:0] WMASK_A_CTL0 = 8'hff;
  localparam logic [7:0] WMASK_A_CTL1 = 8'hfb;
  localparam logic [7:0] WMASK_B_CTL0 = 8'hff;
  localparam logic [7:0] WMASK_B_CTL1 = 8'h3b;

  // ----------------------------------------------------------------
  // field encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    POS_NONE = 2'h0,
    POS_PIN = 2'h1,
    POS_AMP_B = 2'h2,
    POS_REF0 = 2'h3
  } pos_sel_t;

  typedef enum logic [1:0] {
    NEG_PIN = 2'h0,
    NEG_GAIN = 2'h1,
    NEG_UNITY = 2'h2,
    NEG_RSVD = 2'h3
  } neg_sel_t;

  // gain in quarter steps (x4) so 3.75x stays an integer: 15
  localparam logic [7:0] GAIN_X4 [16] = '{
    8'h06, 8'h08, 8'h0a, 8'h0c, 8'h0f, 8'h10, 8'h14, 8'h18,
    8'h1e, 8'h20, 8'h28, 8'h30, 8'h3c, 8'h50, 8'h78, 8'hf0
  };
  localparam logic [7:0] GAIN_UNITY_X4 = 8'h04;

endpackage

// file: hw/opamp_config_registers.sv
/*
  Configuration register bank for the two on-chip amplifiers, with
  decoded control lines for the first amplifier and the shared
  power mode.
  Assumes an Avalon-MM master on clk, 32-bit data, word addressed
  by byte address; analog controls are static levels.
*/
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/1ps
module opamp_config_registers
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // avalon-mm slave
  input wire logic [opamp_cfg_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic [1:0] response,
  // first amplifier analog controls
  output logic outputPinConnect,
  output logic [1:0] positiveInputSelect,
  output logic [1:0] negativeInputSelect,
  output logic gainNetworkEnable,
  output logic [3:0] gainCode,
  output logic [7:0] gainTimesFour,
  // shared power mode
  output logic normalPowerMode
);

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  logic [7:0] ampAOutInCfg; // first amp control 0
  logic [7:0] ampAGainPwrCfg; // first amp control 1
  logic [7:0] ampBOutInCfg; // second amp control 0
  logic [7:0] ampBCurrentCfg; // second amp control 1
  logic accessDone; // one answer cycle per request

  // ----------------------------------------------------------------
  // local codes
  // ----------------------------------------------------------------
  // register numbers handed out by the address decoder
  localparam logic [2:0] SEL_A_CTL0 = 3'h0; // first amp control 0
  localparam logic [2:0] SEL_A_CTL1 = 3'h1; // first amp control 1
  localparam logic [2:0] SEL_B_CTL0 = 3'h2; // second amp control 0
  localparam logic [2:0] SEL_B_CTL1 = 3'h3; // second amp control 1
  localparam logic [2:0] SEL_NONE = 3'h4; // unmapped or misaligned
  // bus response codes
  localparam logic [1:0] RESP_OKAY = 2'h0; // access served
  localparam logic [1:0] RESP_SLVERR = 2'h2; // nothing at that address
  localparam logic [31:0] READ_IDLE = 32'h0000_0000; // idle read data
  // the decoder slices the index straight out of the byte address,
  // so any other width would misalign the whole register map
  if (opamp_cfg_pkg::ADDR_W != $bits(opamp_cfg_pkg::IDX_A_CTL0) + 2)
  begin : g_addr_width_check
    $error("address width must be two bits wider than the index");
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // map a byte address to a register number, 4 for unmapped
  function automatic logic [2:0] decode
  (
    input logic [opamp_cfg_pkg::ADDR_W-1:0] addr
  );
    logic [11:0] idx;
    idx = addr[opamp_cfg_pkg::ADDR_W-1:2];
    if (addr[1:0] != 2'h0)
    begin
      decode = SEL_NONE;
    end
    else if (idx == opamp_cfg_pkg::IDX_A_CTL0)
    begin
      decode = SEL_A_CTL0;
    end
    else if (idx == opamp_cfg_pkg::IDX_A_CTL1)
    begin
      decode = SEL_A_CTL1;
    end
    else if (idx == opamp_cfg_pkg::IDX_B_CTL0)
    begin
      decode = SEL_B_CTL0;
    end
    else if (idx == opamp_cfg_pkg::IDX_B_CTL1)
    begin
      decode = SEL_B_CTL1;
    end
    else
    begin
      decode = SEL_NONE;
    end
  endfunction

  // merge a write into a register, keeping read-only bits
  function automatic logic [7:0] merge
  (
    input logic [7:0] old,
    input logic [7:0] wdata,
    input logic [7:0] wmask
  );
    merge = (old & ~wmask) | (wdata & wmask);
  endfunction

  logic [2:0] regSel; // decoded target
  logic writeHit; // write lands on this edge
  assign regSel = decode(address);
  // a write lands on the edge where waitrequest is sampled low, so
  // master and register agree on which edge took the data; with
  // byte lane 0 off nothing is stored
  assign writeHit = write && accessDone && byteenable[0];

  // ----------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------
  // waitrequest sits high until the cycle after a request is seen,
  // then drops for exactly one cycle
  // the fixed wait state costs a cycle per access but keeps readdata
  // and response straight from flip-flops
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      accessDone <= 1'b0;
      waitrequest <= 1'b1;
    end
    else if ((read || write) && !accessDone)
    begin
      accessDone <= 1'b1;
      waitrequest <= 1'b0;
    end
    else
    begin
      accessDone <= 1'b0;
      waitrequest <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  // map of four byte registers; the data takes effect on the edge
  // where waitrequest is low, matching the master's sampling
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ampAOutInCfg <= opamp_cfg_pkg::RST_A_CTL0;
      ampAGainPwrCfg <= opamp_cfg_pkg::RST_A_CTL1;
      ampBOutInCfg <= opamp_cfg_pkg::RST_B_CTL0;
      ampBCurrentCfg <= opamp_cfg_pkg::RST_B_CTL1;
    end
    else if (writeHit)
    begin
      case (regSel)
        SEL_A_CTL0:
        begin
          // reserved 6:2 are stored; software is expected to keep 0
          ampAOutInCfg <= merge(ampAOutInCfg, writedata[7:0],
            opamp_cfg_pkg::WMASK_A_CTL0);
        end
        SEL_A_CTL1:
        begin
          // bit 2 is read-only and ignores writes
          ampAGainPwrCfg <= merge(ampAGainPwrCfg, writedata[7:0],
            opamp_cfg_pkg::WMASK_A_CTL1);
        end
        SEL_B_CTL0:
        begin
          ampBOutInCfg <= merge(ampBOutInCfg, writedata[7:0],
            opamp_cfg_pkg::WMASK_B_CTL0);
        end
        SEL_B_CTL1:
        begin
          ampBCurrentCfg <= merge(ampBCurrentCfg, writedata[7:0],
            opamp_cfg_pkg::WMASK_B_CTL1);
        end
        default:
        begin
          // unmapped: nothing stored
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read data and response
  // ----------------------------------------------------------------
  // byte sits in bits 7:0, upper bits read zero; the value is taken
  // when the request is first seen and stands for the answer cycle
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      readdata <= READ_IDLE;
    end
    else if ((read || write) && !accessDone)
    begin
      case (regSel)
        SEL_A_CTL0:
        begin
          readdata <= {24'h000000, ampAOutInCfg};
        end
        SEL_A_CTL1:
        begin
          readdata <= {24'h000000, ampAGainPwrCfg};
        end
        SEL_B_CTL0:
        begin
          readdata <= {24'h000000, ampBOutInCfg};
        end
        SEL_B_CTL1:
        begin
          readdata <= {24'h000000, ampBCurrentCfg};
        end
        default:
        begin
          // unmapped reads return zero
          readdata <= READ_IDLE;
        end
      endcase
    end
    else
    begin
      // back to zero outside the answer cycle
      readdata <= READ_IDLE;
    end
  end

  // slave error for an unmapped or misaligned address, for reads and
  // writes alike, so software learns of a stray access either way
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      response <= RESP_OKAY;
    end
    else if ((read || write) && !accessDone && regSel == SEL_NONE)
    begin
      response <= RESP_SLVERR;
    end
    else
    begin
      response <= RESP_OKAY;
    end
  end

  // ----------------------------------------------------------------
  // analog control decode
  // ----------------------------------------------------------------
  // controls are computed from the value each register is about to
  // hold, so they change on the very edge that stores the write
  logic [7:0] next_aCtl0; // value control 0 will hold
  logic [7:0] next_aCtl1; // value control 1 will hold
  logic [7:0] next_bCtl1; // value second amp control 1 will hold
  always_comb
  begin
    next_aCtl0 = ampAOutInCfg;
    next_aCtl1 = ampAGainPwrCfg;
    next_bCtl1 = ampBCurrentCfg;
    if (writeHit)
    begin
      if (regSel == SEL_A_CTL0)
      begin
        next_aCtl0 = merge(ampAOutInCfg, writedata[7:0],
          opamp_cfg_pkg::WMASK_A_CTL0);
      end
      if (regSel == SEL_A_CTL1)
      begin
        next_aCtl1 = merge(ampAGainPwrCfg, writedata[7:0],
          opamp_cfg_pkg::WMASK_A_CTL1);
      end
      if (regSel == SEL_B_CTL1)
      begin
        next_bCtl1 = merge(ampBCurrentCfg, writedata[7:0],
          opamp_cfg_pkg::WMASK_B_CTL1);
      end
    end
  end

  // pin route and positive input, straight from flip-flops
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      outputPinConnect <= 1'b0;
      positiveInputSelect <= opamp_cfg_pkg::POS_NONE;
    end
    else
    begin
      // pin route only; the pin's alternate function is set elsewhere
      outputPinConnect <=
        next_aCtl0[opamp_cfg_pkg::OUTCON_BIT];
      positiveInputSelect <=
        next_aCtl0[opamp_cfg_pkg::INP_LO +: 2];
    end
  end

  // negative input and gain network, straight from flip-flops
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      negativeInputSelect <= opamp_cfg_pkg::NEG_PIN;
      gainNetworkEnable <= 1'b0;
      gainCode <=
        opamp_cfg_pkg::RST_A_CTL1[opamp_cfg_pkg::GAIN_LO +: 4];
      gainTimesFour <= opamp_cfg_pkg::GAIN_UNITY_X4;
    end
    else
    begin
      negativeInputSelect <=
        next_aCtl1[opamp_cfg_pkg::INN_LO +: 2];
      // raw code always visible; only the applied gain is gated
      gainCode <= next_aCtl1[opamp_cfg_pkg::GAIN_LO +: 4];
      // gain only applies through the internal network
      if (next_aCtl1[opamp_cfg_pkg::INN_LO +: 2]
          == opamp_cfg_pkg::NEG_GAIN)
      begin
        gainNetworkEnable <= 1'b1;
        gainTimesFour <= opamp_cfg_pkg::GAIN_X4[
          next_aCtl1[opamp_cfg_pkg::GAIN_LO +: 4]];
      end
      else
      begin
        // pin, unity or reserved feedback: the network stays out
        gainNetworkEnable <= 1'b0;
        gainTimesFour <= opamp_cfg_pkg::GAIN_UNITY_X4;
      end
    end
  end

  // shared power mode for both amplifiers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      normalPowerMode <= 1'b0;
    end
    else
    begin
      // either amplifier asking for normal power lifts both
      normalPowerMode <= next_aCtl1[opamp_cfg_pkg::POWER_BIT]
        | next_bCtl1[opamp_cfg_pkg::POWER_BIT];
    end
  end

endmodule

// file: sim/opamp_cfg_asserts.sv
/*
  Checker for the amplifier register bank: bus handshake, read-only
  zero bits, slave error and the decoded control levels.
  Assumes it sees only the top module's ports, bound in from below.
*/
`timescale 1ns/1ps
module opamp_cfg_asserts
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register bus
  input wire logic [opamp_cfg_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic [1:0] response,
  // amplifier controls
  input wire logic outputPinConnect,
  input wire logic [1:0] positiveInputSelect,
  input wire logic [1:0] negativeInputSelect,
  input wire logic gainNetworkEnable,
  input wire logic [3:0] gainCode,
  input wire logic [7:0] gainTimesFour,
  input wire logic normalPowerMode
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // an access in its answer cycle
  sequence s_ack;
    !waitrequest && (read || write);
  endsequence
  // a write that lands in the register at byte address a
  sequence s_wr(a);
    s_ack and (write && address == a && byteenable[0]);
  endsequence
  property p_take;
    (read || write) && waitrequest |=> !waitrequest;
  endproperty
  a_take: assert property (p_take)
    else $error("request not answered after one cycle");
  property p_one;
    !waitrequest |=> waitrequest;
  endproperty
  a_one: assert property (p_one)
    else $error("answer held longer than one cycle");
  property p_gain_en;
    gainNetworkEnable == (negativeInputSelect == 2'h1);
  endproperty
  a_gain_en: assert property (p_gain_en)
    else $error("gain network enable wrong");
  property p_unity;
    negativeInputSelect != 2'h1 |-> gainTimesFour == 8'h04;
  endproperty
  a_unity: assert property (p_unity)
    else $error("gain applied outside gain network mode");
  property p_table;
    gainNetworkEnable |->
      gainTimesFour == opamp_cfg_pkg::GAIN_X4[gainCode];
  endproperty
  a_table: assert property (p_table)
    else $error("gain value does not match code");
  property p_conn;
    s_wr(14'h3e50) |=> outputPinConnect == $past(writedata[7])
      && positiveInputSelect == $past(writedata[1:0]);
  endproperty
  a_conn: assert property (p_conn)
    else $error("output or input select not taken from write");
  property p_power;
    s_wr(14'h3e55 - 14'h1) ##0 writedata[3] |=> normalPowerMode;
  endproperty
  a_power: assert property (p_power)
    else $error("power select not merged");
  property p_rsvd;
    s_ack and (read && address == 14'h3e54) |->
      readdata[2] == 1'b0 && readdata[31:8] == 24'h0;
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("read-only bit not zero");
  // second amp control 1 keeps 7:6 and 2 read-only, even when written
  property p_rsvd_b;
    s_ack and (read && address == 14'h3e5c) |->
      readdata[7:6] == 2'h0 && readdata[2] == 1'b0;
  endproperty
  a_rsvd_b: assert property (p_rsvd_b)
    else $error("second amp read-only bits not zero");
  property p_map;
    s_ack |-> response == ((address[13:4] == 10'h3e5 &&
      address[1:0] == 2'h0) ? 2'h0 : 2'h2);
  endproperty
  a_map: assert property (p_map)
    else $error("response wrong for address");
endmodule

bind opamp_config_registers opamp_cfg_asserts chk (.clk, .rst_n,
  .address, .read, .write, .writedata, .byteenable, .readdata,
  .waitrequest, .response, .outputPinConnect, .positiveInputSelect,
  .negativeInputSelect, .gainNetworkEnable, .gainCode, .gainTimesFour,
  .normalPowerMode);

// file: sim/opamp_config_registers_test.sv
/*
  Self-checking bench for the amplifier register bank: bus tasks,
  a queue of expected answers and a monitor that compares them.
  Assumes the checker is bound in from its own file.
*/
`timescale 1ns/1ps
module opamp_config_registers_test;
  // ----------------------------------------------------------------
  // signals and reference model
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [13:0] address = 14'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic [1:0] response;
  logic outputPinConnect;
  logic [1:0] positiveInputSelect;
  logic [1:0] negativeInputSelect;
  logic gainNetworkEnable;
  logic [3:0] gainCode;
  logic [7:0] gainTimesFour;
  logic normalPowerMode;
  int n_errors = 0;
  int n_checks = 0;
  logic [34:0] expQ [$]; // read flag, response, data
  logic [7:0] mdl [4] = '{8'h00, 8'h00, 8'h00, 8'h00}; // expected regs
  logic [7:0] wmask [4] = '{8'hff, 8'hfb, 8'hff, 8'h3b};
  // gains in quarter steps, so 3.75 stays whole
  logic [7:0] gainTbl [16] = '{8'h06, 8'h08, 8'h0a, 8'h0c, 8'h0f,
    8'h10, 8'h14, 8'h18, 8'h1e, 8'h20, 8'h28, 8'h30, 8'h3c, 8'h50,
    8'h78, 8'hf0};
  logic [13:0] a;
  logic [7:0] d;

  opamp_config_registers uut (.clk, .rst_n, .address, .read, .write,
    .writedata, .byteenable, .readdata, .waitrequest, .response,
    .outputPinConnect, .positiveInputSelect, .negativeInputSelect,
    .gainNetworkEnable, .gainCode, .gainTimesFour, .normalPowerMode);

  // 40 MHz clock
  initial
  begin
    forever #12.5 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // one access, left up so the next may follow back to back
  task automatic access(input logic rd, input logic [13:0] ad,
    input logic [7:0] d, input logic [3:0] be);
    logic [31:0] r;
    logic ok;
    r = $urandom;
    ok = ad[13:4] == 10'h3e5 && ad[1:0] == 2'h0;
    expQ.push_back({rd, ok ? 2'h0 : 2'h2,
      ok && rd ? {24'h0, mdl[ad[3:2]]} : 32'h0});
    if (!rd && ok && be[0])
      mdl[ad[3:2]] = d & wmask[ad[3:2]];
    read <= rd;
    write <= !rd;
    address <= ad;
    writedata <= {r[31:8], d};
    byteenable <= be;
    // no fixed latency assumed: only the watchdog ends a stuck wait
    do
    begin
      @(posedge clk);
    end
    while (waitrequest !== 1'b0);
  endtask

  task automatic idle();
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask

  // control levels against the model
  task automatic checkCtl();
    logic [1:0] n;
    logic [7:0] g;
    n = mdl[1][1:0];
    g = n == 2'h1 ? gainTbl[mdl[1][7:4]] : 8'h04;
    check({31'h0, outputPinConnect}, {31'h0, mdl[0][7]});
    check({30'h0, positiveInputSelect}, {30'h0, mdl[0][1:0]});
    check({30'h0, negativeInputSelect}, {30'h0, n});
    check({28'h0, gainCode}, {28'h0, mdl[1][7:4]});
    check({31'h0, gainNetworkEnable}, {31'h0, n == 2'h1});
    check({24'h0, gainTimesFour}, {24'h0, g});
    check({31'h0, normalPowerMode}, {31'h0, mdl[1][3] | mdl[3][3]});
  endtask

  // monitor: each answer takes the oldest note
  always @(posedge clk)
  begin : mon
    logic [34:0] e;
    if (rst_n && waitrequest === 1'b0 && expQ.size() > 0)
    begin
      e = expQ.pop_front();
      check({30'h0, response}, {30'h0, e[33:32]});
      if (e[34])
        check(readdata, e[31:0]);
    end
  end

  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // watchdog, well beyond the some 820 cycles the tests need
  initial
  begin
    repeat (5000) @(posedge clk);
    n_errors++;
    end_sim();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(32'h678db893));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    checkCtl();
    for (int k = 0; k < 4; k++)
      access(1'b1, 14'h3e50 + 14'(4 * k), 8'h00, 4'hf);
    access(1'b0, 14'h3e60, 8'hff, 4'hf);
    access(1'b1, 14'h3e52, 8'h00, 4'hf);
    idle();
    $display("test reset and map done");
    // random writes with read-back, byte enable off now and then
    repeat (30)
    begin
      a = 14'h3e50 + {10'h0, 2'($urandom_range(3)), 2'h0};
      d = 8'($urandom);
      // software keeps reserved bits of the first amp registers zero
      if (a[3:2] == 2'h0)
        d = d & 8'h83;
      if (a[3:2] == 2'h1)
        d = d & 8'hfb;
      access(1'b0, a, d, 4'($urandom));
      access(1'b1, a, 8'h00, 4'hf);
      idle();
      checkCtl();
    end
    $display("test random access done");
    // every gain code under every negative select, power both ways
    for (int g = 0; g < 128; g++)
    begin
      access(1'b0, 14'h3e54, {g[3:0], g[4], 1'b0, g[6:5]}, 4'h1);
      access(1'b0, 14'h3e5c, 8'($urandom), 4'h1);
      idle();
      checkCtl();
    end
    $display("test gain and power done");
    // reset in mid-run brings every register back to zero
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    mdl = '{8'h00, 8'h00, 8'h00, 8'h00};
    @(posedge clk);
    checkCtl();
    for (int k = 0; k < 4; k++)
      access(1'b1, 14'h3e50 + 14'(4 * k), 8'h00, 4'hf);
    idle();
    check(32'(expQ.size()), 32'h0);
    $display("test reset in mid-run done");
    end_sim();
  end
endmodule
